// ==== rcsw_reset_sleep.sv ====
`timescale 1ns/1ps
`include "rcsw_regs.svh"

// Overview of operation
// - Watchdog wake from sleep clears all three flags
// - Awake watchdog reset clears pin-wake and timeout
// - Clear-pin wake: pin-wake 0, timeout 1, powerdown 0
// - Power-up: timeout 1, powerdown 1, pin-wake 0
// - Awake clear-pin reset clears only pin-wake
// - Pin wake: pin-wake 1, timeout 1, powerdown 0
// - Flags hold their value until a reset or the sleep instruction
// - Sleep entered only by the sleep instruction
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Sleep stops oscillator driver and core clock
// - Port pins keep their drive during sleep
// - Watchdog reset never drives the clear pin
// - Wake on clear pin, watchdog or pin change
// - Every wake is a full device reset
// - A watchdog time-out clears the timeout flag unless the clear pin is low in the same cycle
// - Pin-wake compares pins with last port read
// - Stale pin mismatch wakes immediately on sleep
// - Watchdog cleared on every wake
// - Watchdog wake also runs the reset delay timer
module rcsw_reset_sleep #(
  parameter int DRT_POR_CYCLES = (`RCSW_DRT_POR_NS + `RCSW_CLK_NS - 1) / `RCSW_CLK_NS,
  parameter int WDT_CYCLES = `RCSW_WDT_PERIOD_NS / `RCSW_CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Core instruction events
  input wire logic sleepExec,
  input wire logic clrWdtExec,
  input wire logic portRead,
  // Configuration
  input wire logic mclrEnable,
  input wire logic wdtEnable,
  input wire logic wakeOnChangeEn,
  // External pins
  input wire logic masterClearPinN,
  input wire logic wakePin0,
  input wire logic wakePin1,
  input wire logic wakePin3,
  input wire logic wakePin4,
  // Port drive from the core
  input wire logic [`RCSW_PORT_W-1:0] portOutIn,
  input wire logic [`RCSW_PORT_W-1:0] portOeIn,
  // Reset cause flags
  output logic timeoutFlagN,
  output logic powerdownFlagN,
  output logic pinWakeFlag,
  // Core reset and clocking
  output logic coreResetN,
  output logic coreClkEn,
  output logic oscDriverEn,
  // Pin drive
  output logic [`RCSW_PORT_W-1:0] portOut,
  output logic [`RCSW_PORT_W-1:0] portOe,
  output logic masterClearPinOe
);

  localparam int DRT_SUB_CYCLES = (`RCSW_DRT_SUB_NS + `RCSW_CLK_NS - 1) / `RCSW_CLK_NS;

  if (WDT_CYCLES < 2 || DRT_POR_CYCLES < DRT_SUB_CYCLES) begin : g_chk
    $error("rcsw_reset_sleep: timer parameters out of range");
  end

  rcsw_pkg::rcsw_top_s r;
  rcsw_pkg::rcsw_top_s n;

  logic [`RCSW_WAKE_W-1:0] wakeNow;
  logic mclrLow;
  logic pinMismatch;
  logic wdtFire;
  logic wdtClear;
  logic drtStart;
  logic drtExpired;

  // ----------------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------------
  assign wakeNow = {wakePin4, wakePin3, wakePin1, wakePin0};
  assign mclrLow = mclrEnable && !masterClearPinN;
  assign pinMismatch = wakeOnChangeEn && (wakeNow != r.wakeRef);

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  assign wdtClear = (clrWdtExec && r.mode == rcsw_pkg::RCSW_RUN)
    || (n.mode != r.mode) || (r.mode == rcsw_pkg::RCSW_HOLD);
  assign drtStart = (r.mode != rcsw_pkg::RCSW_HOLD) && (n.mode == rcsw_pkg::RCSW_HOLD);

  rcsw_wdt #(
    .CYCLES(WDT_CYCLES)
  ) u_wdt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(wdtEnable),
    .clear(wdtClear),
    .timeout(wdtFire)
  );

  rcsw_drt #(
    .POR_CYCLES(DRT_POR_CYCLES),
    .SUB_CYCLES(DRT_SUB_CYCLES)
  ) u_drt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(drtStart),
    .hold(mclrLow),
    .expired(drtExpired)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    n.mclrOe = 1'b0;
    unique case (r.mode)
      rcsw_pkg::RCSW_RUN: begin
        n.portOut = portOutIn;
        n.portOe = portOeIn;
        if (portRead) begin
          n.wakeRef = wakeNow;
        end
        if (mclrLow) begin
          n.pwf = 1'b0;
          n.mode = rcsw_pkg::RCSW_HOLD;
          n.coreRstN = 1'b0;
        end else if (wdtFire) begin
          n.toN = 1'b0;
          n.pwf = 1'b0;
          n.mode = rcsw_pkg::RCSW_HOLD;
          n.coreRstN = 1'b0;
        end else if (sleepExec) begin
          n.toN = 1'b1;
          n.pdN = 1'b0;
          n.mode = rcsw_pkg::RCSW_SLEEP;
          n.oscEn = 1'b0;
        end
      end
      rcsw_pkg::RCSW_SLEEP: begin
        if (mclrLow) begin
          n.toN = 1'b1;
          n.pdN = 1'b0;
          n.pwf = 1'b0;
        end else if (wdtFire) begin
          n.toN = 1'b0;
          n.pdN = 1'b0;
          n.pwf = 1'b0;
        end else if (pinMismatch) begin
          n.toN = 1'b1;
          n.pdN = 1'b0;
          n.pwf = 1'b1;
        end
        if (mclrLow || wdtFire || pinMismatch) begin
          n.mode = rcsw_pkg::RCSW_HOLD;
          n.coreRstN = 1'b0;
          n.oscEn = 1'b1;
        end
      end
      rcsw_pkg::RCSW_HOLD: begin
        n.portOut = portOutIn;
        n.portOe = portOeIn;
        if (drtExpired && !mclrLow) begin
          n.mode = rcsw_pkg::RCSW_RUN;
          n.coreRstN = 1'b1;
        end
      end
      default: begin
        n.mode = rcsw_pkg::RCSW_HOLD;
        n.coreRstN = 1'b0;
        n.oscEn = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r.mode <= rcsw_pkg::RCSW_HOLD;
      r.toN <= `RCSW_TON_POR;
      r.pdN <= `RCSW_PDN_POR;
      r.pwf <= `RCSW_PWF_POR;
      r.coreRstN <= 1'b0;
      r.oscEn <= 1'b1;
      r.mclrOe <= 1'b0;
      r.wakeRef <= '0;
      r.portOut <= '0;
      r.portOe <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign timeoutFlagN = r.toN;
  assign powerdownFlagN = r.pdN;
  assign pinWakeFlag = r.pwf;
  assign coreResetN = r.coreRstN;
  assign coreClkEn = r.oscEn;
  assign oscDriverEn = r.oscEn;
  assign portOut = r.portOut;
  assign portOe = r.portOe;
  assign masterClearPinOe = r.mclrOe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_wdt_sleep;
    (r.mode == rcsw_pkg::RCSW_SLEEP && !mclrLow && wdtFire)
      |=> (!timeoutFlagN && !powerdownFlagN && !pinWakeFlag);
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog wake flags wrong");

  property p_wdt_run;
    (r.mode == rcsw_pkg::RCSW_RUN && !mclrLow && wdtFire)
      |=> (!timeoutFlagN && !pinWakeFlag && powerdownFlagN == $past(powerdownFlagN));
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("awake watchdog flags wrong");

  property p_master_clear_pin_sleep;
    (r.mode == rcsw_pkg::RCSW_SLEEP && mclrLow)
      |=> (timeoutFlagN && !powerdownFlagN && !pinWakeFlag && !coreResetN);
  endproperty
  a_master_clear_pin_sleep: assert property (p_master_clear_pin_sleep) else $error("clear pin wake flags wrong");

  property p_master_clear_pin_run;
    (r.mode == rcsw_pkg::RCSW_RUN && mclrLow)
      |=> (!pinWakeFlag && timeoutFlagN == $past(timeoutFlagN)
        && powerdownFlagN == $past(powerdownFlagN));
  endproperty
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("awake clear pin flags wrong");

  property p_pin_wake;
    (r.mode == rcsw_pkg::RCSW_SLEEP && !mclrLow && !wdtFire && pinMismatch)
      |=> (pinWakeFlag && timeoutFlagN && !powerdownFlagN && r.mode == rcsw_pkg::RCSW_HOLD);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags wrong");

  property p_flags_keep;
    (r.mode == rcsw_pkg::RCSW_RUN && !mclrLow && !wdtFire && !sleepExec)
      |=> $stable({timeoutFlagN, powerdownFlagN, pinWakeFlag});
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("flags changed without reset");

  property p_sleep_entry;
    (r.mode != rcsw_pkg::RCSW_SLEEP ##1 r.mode == rcsw_pkg::RCSW_SLEEP)
      |-> ($past(sleepExec) && timeoutFlagN && !powerdownFlagN);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered wrongly");

  property p_osc_off;
    (r.mode == rcsw_pkg::RCSW_SLEEP) |-> (!oscDriverEn && !coreClkEn);
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("clock running in sleep");

  property p_port_hold;
    (r.mode == rcsw_pkg::RCSW_SLEEP ##1 r.mode == rcsw_pkg::RCSW_SLEEP)
      |-> ($stable(portOut) && $stable(portOe));
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port drive moved in sleep");

  property p_master_clear_pin_quiet;
    (wdtFire ##1 1'b1) |-> !masterClearPinOe;
  endproperty
  a_master_clear_pin_quiet: assert property (p_master_clear_pin_quiet) else $error("clear pin driven");

  property p_drt_hold;
    (r.mode == rcsw_pkg::RCSW_SLEEP && wdtFire)
      |=> (!coreResetN [*8]);
  endproperty
  a_drt_hold: assert property (p_drt_hold) else $error("reset delay skipped");

  property p_hold_wdt;
    (r.mode == rcsw_pkg::RCSW_HOLD)
      |-> !wdtFire;
  endproperty
  a_hold_wdt: assert property (p_hold_wdt) else $error("watchdog ran in reset");

  property p_sleep_wdt;
    (r.mode == rcsw_pkg::RCSW_RUN && sleepExec && !mclrLow && !wdtFire)
      |=> !wdtFire;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

  property p_wake_source;
    (r.mode == rcsw_pkg::RCSW_SLEEP ##1 r.mode == rcsw_pkg::RCSW_HOLD)
      |-> ($past(mclrLow) || $past(wdtFire) || $past(pinMismatch));
  endproperty
  a_wake_source: assert property (p_wake_source) else $error("wake without a source");

  property p_wake_reset;
    (r.mode == rcsw_pkg::RCSW_SLEEP ##1 r.mode != rcsw_pkg::RCSW_SLEEP)
      |-> (!coreResetN && coreClkEn && oscDriverEn);
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("wake did not reset");

  property p_hold_reset;
    (r.mode == rcsw_pkg::RCSW_HOLD)
      |-> !coreResetN;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("core left reset early");

  property p_clk_run;
    (r.mode != rcsw_pkg::RCSW_SLEEP)
      |-> (coreClkEn && oscDriverEn);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock stopped while awake");

  property p_to_clear;
    (r.mode != rcsw_pkg::RCSW_HOLD && !mclrLow && wdtFire)
      |=> !timeoutFlagN;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout flag not cleared");

  property p_ref_latch;
    (r.mode == rcsw_pkg::RCSW_RUN && portRead)
      |=> (r.wakeRef == $past(wakeNow));
  endproperty
  a_ref_latch: assert property (p_ref_latch) else $error("wake reference not taken");

  property p_stale_wake;
    (r.mode != rcsw_pkg::RCSW_SLEEP ##1 (r.mode == rcsw_pkg::RCSW_SLEEP && pinMismatch
      && !mclrLow && !wdtFire)) |=> (pinWakeFlag && !coreResetN);
  endproperty
  a_stale_wake: assert property (p_stale_wake) else $error("stale pin wake missed");

  property p_port_follow;
    (r.mode != rcsw_pkg::RCSW_SLEEP)
      |=> (portOut == $past(portOutIn) && portOe == $past(portOeIn));
  endproperty
  a_port_follow: assert property (p_port_follow) else $error("port drive not passed");

  c_sleep: cover property (r.mode == rcsw_pkg::RCSW_RUN && sleepExec && !mclrLow && !wdtFire);
  c_wdt_wake: cover property (r.mode == rcsw_pkg::RCSW_SLEEP && wdtFire && !mclrLow);
  c_pin_wake: cover property (r.mode == rcsw_pkg::RCSW_SLEEP && pinMismatch && !wdtFire);
  c_master_clear_pin_wake: cover property (r.mode == rcsw_pkg::RCSW_SLEEP && mclrLow);
  c_stale_wake: cover property (r.mode == rcsw_pkg::RCSW_RUN && sleepExec && pinMismatch);

endmodule // rcsw_reset_sleep

// ==== rcsw_regs.svh ====
`ifndef RCSW_REGS_SVH
`define RCSW_REGS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RCSW_CLK_NS 25
`define RCSW_DRT_POR_NS 18000000
`define RCSW_DRT_SUB_NS 10000
`define RCSW_WDT_PERIOD_NS 18000000

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define RCSW_PORT_W 6
`define RCSW_WAKE_W 4
`define RCSW_TON_POR 1'h1
`define RCSW_PDN_POR 1'h1
`define RCSW_PWF_POR 1'h0

`endif

// ==== rcsw_pkg.sv ====
`include "rcsw_regs.svh"

package rcsw_pkg;

  // --------------------------------------------------------------------
  // Sequencer modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    RCSW_RUN = 2'h0,
    RCSW_SLEEP = 2'h1,
    RCSW_HOLD = 2'h3
  } rcsw_mode_e;

  // --------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------
  typedef struct packed {
    rcsw_mode_e mode;
    logic toN;
    logic pdN;
    logic pwf;
    logic coreRstN;
    logic oscEn;
    logic mclrOe;
    logic [`RCSW_WAKE_W-1:0] wakeRef;
    logic [`RCSW_PORT_W-1:0] portOut;
    logic [`RCSW_PORT_W-1:0] portOe;
  } rcsw_top_s;

endpackage

// ==== rcsw_wdt.sv ====
`timescale 1ns/1ps

module rcsw_wdt #(
  parameter int CYCLES = 720000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Control
  input wire logic enable,
  input wire logic clear,
  // Event
  output logic timeout
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic fire;
  } rcsw_wdt_s;

  rcsw_wdt_s r;
  rcsw_wdt_s n;

  if (CYCLES < 2) begin : g_chk
    $error("rcsw_wdt: CYCLES must be at least 2");
  end

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  always_comb begin
    n = r;
    n.fire = 1'b0;
    if (clear || !enable) begin
      n.cnt = '0;
    end else if (r.cnt == CW'(CYCLES - 1)) begin
      n.cnt = '0;
      n.fire = 1'b1;
    end else begin
      n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign timeout = r.fire;

endmodule // rcsw_wdt

// ==== rcsw_drt.sv ====
`timescale 1ns/1ps

module rcsw_drt #(
  parameter int POR_CYCLES = 720000,
  parameter int SUB_CYCLES = 400
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic hold,
  // Status
  output logic expired
);

  localparam int CW = $clog2(POR_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic isPor;
  } rcsw_drt_s;

  rcsw_drt_s r;
  rcsw_drt_s n;

  if (SUB_CYCLES < 1 || POR_CYCLES < SUB_CYCLES) begin : g_chk
    $error("rcsw_drt: need 1 <= SUB_CYCLES <= POR_CYCLES");
  end

  // --------------------------------------------------------------------
  // Delay counter, restarted while the clear pin is held low
  // --------------------------------------------------------------------
  always_comb begin
    n = r;
    if (start) begin
      n.cnt = CW'(SUB_CYCLES);
      n.isPor = 1'b0;
    end else if (hold) begin
      n.cnt = r.isPor ? CW'(POR_CYCLES) : CW'(SUB_CYCLES);
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r.cnt <= CW'(POR_CYCLES);
      r.isPor <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign expired = (r.cnt == '0);

endmodule // rcsw_drt

// ==== rcsw_core_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Core software model: port read then sleep instruction
// ----------------------------------------------------------------------
module rcsw_core_model (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic goSleep,
  input wire logic skipRead,
  // Core instruction events
  output logic portRead,
  output logic sleepExec
);
  logic [1:0] step = 2'h0;

  always @(posedge clk_sys) begin
    if (step == 2'h0) begin
      step <= #2 {1'b0, goSleep};
    end else begin
      step <= #2 (step == 2'h2) ? 2'h0 : step + 2'h1;
    end
  end

  assign portRead = (step == 2'h1) && !skipRead;
  assign sleepExec = (step == 2'h2);
endmodule // rcsw_core_model

// ==== tb_rcsw_reset_sleep.sv ====
`timescale 1ns/1ps
`include "rcsw_regs.svh"

module tb_rcsw_reset_sleep;
  logic clk_sys, arst_n, clrWdtExec, mclrEnable, wdtEnable, wakeOnChangeEn;
  logic masterClearPinN, goSleep, skipRead, portRead, sleepExec;
  logic [3:0] wp;
  logic [`RCSW_PORT_W-1:0] pOutIn, pOeIn, pOut, pOe;
  logic toN, pdN, pwf, coreResetN, coreClkEn, oscDriverEn, masterClearPinOe;
  logic [7:0] seed;
  int err_total, n_compared, mTo, mPd, mPw;

  rcsw_reset_sleep #(.DRT_POR_CYCLES(500), .WDT_CYCLES(40)) u_rcsw_reset_sleep (
    .clk_sys(clk_sys), .arst_n(arst_n), .sleepExec(sleepExec), .clrWdtExec(clrWdtExec),
    .portRead(portRead), .mclrEnable(mclrEnable), .wdtEnable(wdtEnable),
    .wakeOnChangeEn(wakeOnChangeEn), .masterClearPinN(masterClearPinN),
    .wakePin0(wp[0]), .wakePin1(wp[1]), .wakePin3(wp[2]), .wakePin4(wp[3]),
    .portOutIn(pOutIn), .portOeIn(pOeIn), .timeoutFlagN(toN), .powerdownFlagN(pdN),
    .pinWakeFlag(pwf), .coreResetN(coreResetN), .coreClkEn(coreClkEn),
    .oscDriverEn(oscDriverEn), .portOut(pOut), .portOe(pOe),
    .masterClearPinOe(masterClearPinOe));

  rcsw_core_model u_rcsw_core_model (.clk_sys(clk_sys), .goSleep(goSleep),
    .skipRead(skipRead), .portRead(portRead), .sleepExec(sleepExec));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic model(input int k, input bit sl);
    case (k)
      0: begin mPw = 0; mTo = 1; mPd = 1; end
      1: begin mPw = 0; if (sl) begin mTo = 1; mPd = 0; end end
      2: begin mPw = 0; mTo = 0; if (sl) mPd = 0; end
      3: begin mPw = 1; mTo = 1; mPd = 0; end
      default: begin mTo = 1; mPd = 0; end
    endcase
  endtask

  task automatic chkFlags();
    chk(pwf, mPw[0]);
    chk(toN, mTo[0]);
    chk(pdN, mPd[0]);
  endtask

  task automatic waitRst(input logic want);
    int i;
    for (i = 0; i < 1000 && coreResetN !== want; i++) tick(1);
    chk(coreResetN, want);
  endtask

  task automatic doSleep(input bit skip);
    seed = lfsr(seed);
    pOutIn = seed[5:0];
    pOeIn = ~seed[5:0];
    skipRead = skip;
    goSleep = 1'b1;
    tick(1);
    goSleep = 1'b0;
    tick(3);
    skipRead = 1'b0;
  endtask

  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    #(25 * 20000);
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'b0; clrWdtExec = 1'b0; mclrEnable = 1'b1; wdtEnable = 1'b0;
    wakeOnChangeEn = 1'b1; masterClearPinN = 1'b1; goSleep = 1'b0; skipRead = 1'b0;
    wp = 4'h0; pOutIn = 6'h00; pOeIn = 6'h00; seed = 8'h5B;
    err_total = 0; n_compared = 0;
    tick(3);
    arst_n = 1'b1;
    model(0, 0);
    chkFlags();
    waitRst(1'b1);
    wdtEnable = 1'b1;
    repeat (3) begin
      tick(30);
      clrWdtExec = 1'b1;
      tick(1);
      clrWdtExec = 1'b0;
    end
    chk(coreResetN, 1'b1);
    waitRst(1'b0);
    model(2, 0);
    chkFlags();
    chk(masterClearPinOe, 1'b0);
    wdtEnable = 1'b0;
    waitRst(1'b1);
    tick(20);
    chkFlags();
    doSleep(0);
    model(4, 0);
    chkFlags();
    chk(coreClkEn, 1'b0);
    chk(oscDriverEn, 1'b0);
    pOutIn = ~pOutIn;
    pOeIn = ~pOeIn;
    tick(3);
    chk(pOut === seed[5:0], 1'b1);
    chk(pOe === ~seed[5:0], 1'b1);
    chk(coreResetN, 1'b1);
    wp = 4'h8;
    tick(3);
    model(3, 1);
    chkFlags();
    chk(coreResetN, 1'b0);
    chk(coreClkEn, 1'b1);
    waitRst(1'b1);
    masterClearPinN = 1'b0;
    tick(2);
    masterClearPinN = 1'b1;
    model(1, 0);
    chkFlags();
    waitRst(1'b1);
    doSleep(0);
    wdtEnable = 1'b1;
    waitRst(1'b0);
    model(2, 1);
    chkFlags();
    wdtEnable = 1'b0;
    waitRst(1'b1);
    doSleep(0);
    masterClearPinN = 1'b0;
    tick(3);
    model(1, 1);
    chkFlags();
    masterClearPinN = 1'b1;
    waitRst(1'b1);
    wp = 4'h3;
    doSleep(1);
    tick(2);
    model(3, 1);
    chkFlags();
    chk(coreResetN, 1'b0);
    waitRst(1'b1);
    arst_n = 1'b0;
    tick(3);
    model(0, 0);
    chkFlags();
    chk(coreResetN, 1'b0);
    arst_n = 1'b1;
    waitRst(1'b1);
    final_report();
  end
endmodule // tb_rcsw_reset_sleep
